/* logic/fbcm_pkg.sv */
// fbcm_pkg: addresses, field positions and encodings of the boot configuration map.
// assumes 24-bit flash-organization byte addresses.
package fbcm_pkg;
    localparam int ADDR_W = 24;
    localparam logic [23:0] CFG_ADDR = 24'h30_0000;
    localparam logic [23:0] LDR_BASE = 24'h10_0000;
    localparam logic [23:0] LDR_LAST = 24'h10_0fff;
    localparam logic [23:0] LDR_SPAN = 24'h00_0fff;
    localparam logic [23:0] DATA_BASE = 24'h01_f000;
    localparam logic [23:0] DATA_LAST = 24'h01_ffff;
    localparam logic [23:0] PAGE_MASK = 24'h00_01ff;
    localparam logic [23:0] MAIN_BASE = 24'h00_0000;
    localparam int KB_BYTES = 1024;
    localparam int MAIN_KB_DEF = 64;
    localparam int WDT_OFF_BIT = 31;
    localparam int WDT_PD_BIT = 30;
    localparam int CLK_HI = 26;
    localparam int CLK_LO = 24;
    localparam int BOD_OFF_BIT = 23;
    localparam int BOD_HI = 22;
    localparam int BOD_LO = 21;
    localparam int BOD_RST_BIT = 20;
    localparam int GPIO_BIT = 10;
    localparam int BOOT_HI = 7;
    localparam int BOOT_LO = 6;
    localparam int LOCK_BIT = 1;
    localparam logic [31:0] CFG_RESET = 32'hffff_ffff;
    localparam logic [31:0] LOCKED_DATA = 32'hffff_ffff;
    localparam logic [2:0] SYSCLK_XTAL = 3'h0;
    localparam logic [2:0] SYSCLK_IRC = 3'h7;
    typedef enum logic [1:0] {
        FBCM_LDR_CROSS = 2'h0,
        FBCM_LDR_ONLY = 2'h1,
        FBCM_MAIN_CROSS = 2'h2,
        FBCM_MAIN_ONLY = 2'h3
    } fbcm_boot_t;
    typedef enum logic [1:0] {
        FBCM_IDLE = 2'h0,
        FBCM_REQ = 2'h1,
        FBCM_WAIT = 2'h3,
        FBCM_DONE = 2'h2
    } fbcm_state_t;
endpackage : fbcm_pkg

/* logic/fbcm_map_if.sv */
// fbcm_map_if: decoded configuration fields and live map state shared inside the block.
// assumes one producer per signal as the modports say.
`timescale 1ns/1ns
`default_nettype none
interface fbcm_map_if;
    logic wdt_en, wdt_lirc, lirc_on, lirc_gated, clk_rsvd;
    logic bod_en, bod_rst, gpio_quasi, locked;
    logic [2:0] clk_src;
    logic [1:0] bod_lvl;
    fbcm_pkg::fbcm_boot_t boot_mode;
    logic boot_loader;
    logic [23:0] vec_base, main_last;
    modport dec(output wdt_en, wdt_lirc, lirc_on, lirc_gated, clk_rsvd, bod_en, bod_rst,
        gpio_quasi, locked, clk_src, bod_lvl, boot_mode);
    modport top(input wdt_en, wdt_lirc, lirc_on, lirc_gated, clk_rsvd, bod_en, bod_rst,
        gpio_quasi, locked, clk_src, bod_lvl, boot_mode, output boot_loader, vec_base, main_last);
    modport map(input boot_mode, boot_loader, vec_base, main_last);
endinterface : fbcm_map_if
`default_nettype wire

/* logic/fbcm_decode.sv */
// fbcm_decode: splits the captured configuration word into its fields.
// assumes the word is held stable by the caller between reboots.
`timescale 1ns/1ns
`default_nettype none
module fbcm_decode (
    input wire logic [31:0] cfg_in, // captured configuration word
    fbcm_map_if.dec d               // decoded fields
);
    always_comb begin
        d.wdt_en = ~cfg_in[fbcm_pkg::WDT_OFF_BIT]; // RULE7
        d.wdt_lirc = ~cfg_in[fbcm_pkg::WDT_OFF_BIT]; // RULE7
        // pd gating bit only means something with the watchdog on
        d.lirc_on = ~cfg_in[fbcm_pkg::WDT_OFF_BIT] & ~cfg_in[fbcm_pkg::WDT_PD_BIT]; // RULE8
        d.lirc_gated = ~cfg_in[fbcm_pkg::WDT_OFF_BIT] & cfg_in[fbcm_pkg::WDT_PD_BIT]; // RULE8
        d.clk_src = cfg_in[fbcm_pkg::CLK_HI:fbcm_pkg::CLK_LO]; // RULE9
        d.clk_rsvd = (d.clk_src != fbcm_pkg::SYSCLK_XTAL)
            && (d.clk_src != fbcm_pkg::SYSCLK_IRC); // RULE9
        d.bod_en = ~cfg_in[fbcm_pkg::BOD_OFF_BIT]; // RULE10
        d.bod_lvl = cfg_in[fbcm_pkg::BOD_HI:fbcm_pkg::BOD_LO]; // RULE11
        d.bod_rst = ~cfg_in[fbcm_pkg::BOD_RST_BIT]; // RULE12
        d.gpio_quasi = cfg_in[fbcm_pkg::GPIO_BIT]; // RULE13
        d.boot_mode = fbcm_pkg::fbcm_boot_t'(cfg_in[fbcm_pkg::BOOT_HI:fbcm_pkg::BOOT_LO]); // RULE14
        d.locked = ~cfg_in[fbcm_pkg::LOCK_BIT]; // RULE18
    end
endmodule : fbcm_decode
`default_nettype wire

/* logic/fbcm_addr_map.sv */
// fbcm_addr_map: turns a cpu address into a flash-organization address.
// assumes main_last, vec_base and boot_loader are stable while in use.
`timescale 1ns/1ns
`default_nettype none
module fbcm_addr_map (
    fbcm_map_if.map m,                 // live map state
    input wire logic [23:0] addr_in,   // cpu byte address
    output logic [23:0] org_out,       // flash-organization address
    output logic hit_out               // address is mapped
);
    always_comb begin
        org_out = '0;
        hit_out = 1'b0;
        if (addr_in >= fbcm_pkg::DATA_BASE && addr_in <= fbcm_pkg::DATA_LAST) begin
            org_out = addr_in; // RULE1
            hit_out = 1'b1;
        end else if (!m.boot_mode[0]) begin
            if (addr_in <= fbcm_pkg::PAGE_MASK) begin
                // vector page mirrors whatever page the base points at
                org_out = m.vec_base | (addr_in & fbcm_pkg::PAGE_MASK); // RULE20
                hit_out = 1'b1;
            end else if (addr_in <= m.main_last) begin
                org_out = addr_in; // RULE15
                hit_out = 1'b1;
            end else if (addr_in >= fbcm_pkg::LDR_BASE && addr_in <= fbcm_pkg::LDR_LAST) begin
                org_out = addr_in; // RULE23
                hit_out = 1'b1;
            end
        end else if (m.boot_loader) begin
            if (addr_in <= fbcm_pkg::LDR_SPAN) begin
                org_out = fbcm_pkg::LDR_BASE | addr_in; // RULE19
                hit_out = 1'b1;
            end
        end else if (addr_in <= m.main_last) begin
            org_out = addr_in; // RULE19
            hit_out = 1'b1;
        end
    end
endmodule : fbcm_addr_map
`default_nettype wire

/* logic/fbcm_top.sv */
// fbcm_top: captures the configuration word at power-up or reboot and applies it.
// assumes a flash read port that answers a request with one valid pulse.
// Summary of operation
// RULE1 - data flash sits at 0x1f000, 4 KB, whatever the main size
// RULE2 - erases only on whole 512-byte page boundaries
// RULE3 - programming commands see the loader at 0x100000..0x100fff always
// RULE4 - main region runs from zero to its fitted size minus one
// RULE5 - configuration is one 32-bit word at 0x300000
// RULE6 - word is captured only at power-up or reboot
// RULE7 - bit 31 low enables watchdog on low-power clock; high leaves it off
// RULE8 - bit 30 low keeps low-power oscillator on; high allows gating
// RULE9 - clock source field 000 crystal, 111 rc, rest reserved, loaded after reset
// RULE10 - bit 23 low enables brown-out detection
// RULE11 - threshold field selects 4.4, 3.7, 2.7 or 2.2 volts
// RULE12 - bit 20 low enables brown-out reset
// RULE13 - bit 10 picks tri-state or quasi-bidirectional gpio start
// RULE14 - boot field: loader+cross, loader, main+cross, main
// RULE15 - cross-execution maps loader high and main at zero
// RULE16 - run-time boot switch works only when boot bit 0 is one
// RULE17 - vector page remap works only when boot bit 0 is zero
// RULE18 - locked debug reads give all ones except id and config
// RULE19 - without cross-execution the other region is not cpu-readable
// RULE20 - mode 00 mirrors loader first page at zero, remappable later
// RULE21 - mode 01 write-protects the loader
// RULE22 - software keeps reserved configuration bits at one
// RULE23 - mode 10 maps loader high, main keeps its space
// RULE24 - mode 11 write-protects the main region
// RULE25 - decoded fields hold between resets despite reprogramming
`timescale 1ns/1ns
`default_nettype none
module fbcm_top #(
    parameter int MAIN_KB = fbcm_pkg::MAIN_KB_DEF // fitted main size: 8, 16, 32 or 64
) (
    input wire logic CORE_CLK_IN,            // system clock
    input wire logic RESET_IN,               // power-on reset, async high
    input wire logic CLK_EN_IN,              // freezes all state when low
    input wire logic REBOOT_IN,              // system reboot, recaptures word
    output logic CFG_RD_REQ_OUT,             // config read request
    output logic [23:0] CFG_RD_ADDR_OUT,     // config read address
    input wire logic [31:0] CFG_RD_DATA_IN,  // config read data
    input wire logic CFG_RD_VALID_IN,        // config read data valid
    input wire logic CPU_REQ_IN,             // cpu read request
    input wire logic [23:0] CPU_ADDR_IN,     // cpu address
    output logic CPU_ACK_OUT,                // translation ready
    output logic CPU_HIT_OUT,                // address is mapped
    output logic [23:0] CPU_ORG_ADDR_OUT,    // translated address
    input wire logic BOOT_SW_WE_IN,          // write run-time boot switch
    input wire logic BOOT_SW_IN,             // 1 = loader boot
    input wire logic VEC_WE_IN,              // vector page remap command
    input wire logic [23:0] VEC_PAGE_IN,     // remap page address
    input wire logic PROG_REQ_IN,            // programming command request
    input wire logic PROG_ERASE_IN,          // 1 = page erase, 0 = word program
    input wire logic [23:0] PROG_ADDR_IN,    // flash-organization address
    output logic PROG_DONE_OUT,              // check result valid
    output logic PROG_OK_OUT,                // command allowed
    input wire logic DBG_RD_VALID_IN,        // debug read data valid
    input wire logic DBG_IS_ID_IN,           // debug read of id or config
    input wire logic [31:0] DBG_RDATA_IN,    // raw debug read data
    output logic DBG_VALID_OUT,              // filtered debug data valid
    output logic [31:0] DBG_RDATA_OUT,       // filtered debug data
    output logic CFG_VALID_OUT,              // fields below are applied
    output logic WDT_EN_OUT,                 // watchdog enabled
    output logic WDT_CLK_LIRC_OUT,           // watchdog forced to low-power osc
    output logic LIRC_ALWAYS_ON_OUT,         // low-power osc kept running
    output logic LIRC_PD_GATED_OUT,          // low-power osc left to its enable
    output logic [2:0] SYSCLK_SRC_OUT,       // system clock source select
    output logic SYSCLK_RSVD_OUT,            // reserved source code seen
    output logic BOD_EN_OUT,                 // brown-out detect enabled
    output logic [1:0] BOD_LEVEL_OUT,        // brown-out threshold code
    output logic BOD_RST_EN_OUT,             // brown-out reset enabled
    output logic GPIO_QUASI_OUT,             // gpio starts quasi-bidirectional
    output logic [1:0] BOOT_MODE_OUT,        // boot select field
    output logic BOOT_LOADER_OUT,            // running from loader
    output logic LOCKED_OUT,                 // flash security lock
    output logic [23:0] VEC_BASE_OUT         // page mirrored at zero
);
    localparam logic [23:0] MAIN_LAST = 24'(MAIN_KB * fbcm_pkg::KB_BYTES - 1);

    fbcm_map_if m();
    fbcm_pkg::fbcm_state_t state;
    logic [31:0] cfg_word;
    logic boot_loader;
    logic [23:0] vec_base;
    logic [23:0] org;
    logic hit;
    logic next_ok;

    assign m.boot_loader = boot_loader;
    assign m.vec_base = vec_base;
    assign m.main_last = MAIN_LAST; // RULE4

    fbcm_decode u_decode (
        .cfg_in(cfg_word),
        .d(m.dec)
    );

    fbcm_addr_map u_map (
        .m(m.map),
        .addr_in(CPU_ADDR_IN),
        .org_out(org),
        .hit_out(hit)
    );

    // capture sequence; reprogramming the word in flash changes nothing here
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state <= fbcm_pkg::FBCM_IDLE;
            cfg_word <= fbcm_pkg::CFG_RESET;
            CFG_RD_REQ_OUT <= 1'b0;
            CFG_RD_ADDR_OUT <= '0;
        end else if (CLK_EN_IN) begin
            if (REBOOT_IN) begin
                state <= fbcm_pkg::FBCM_IDLE; // RULE6
                CFG_RD_REQ_OUT <= 1'b0;
            end else begin
                case (state)
                    fbcm_pkg::FBCM_IDLE: begin
                        state <= fbcm_pkg::FBCM_REQ;
                    end
                    fbcm_pkg::FBCM_REQ: begin
                        CFG_RD_REQ_OUT <= 1'b1;
                        CFG_RD_ADDR_OUT <= fbcm_pkg::CFG_ADDR; // RULE5
                        state <= fbcm_pkg::FBCM_WAIT;
                    end
                    fbcm_pkg::FBCM_WAIT: begin
                        if (CFG_RD_VALID_IN) begin
                            CFG_RD_REQ_OUT <= 1'b0;
                            cfg_word <= CFG_RD_DATA_IN; // RULE6
                            state <= fbcm_pkg::FBCM_DONE;
                        end
                    end
                    fbcm_pkg::FBCM_DONE: begin
                        state <= fbcm_pkg::FBCM_DONE; // RULE25
                    end
                    default: begin
                        state <= fbcm_pkg::FBCM_IDLE;
                    end
                endcase
            end
        end
    end

    // boot selection and vector base take their defaults from the word
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            boot_loader <= 1'b0;
            vec_base <= fbcm_pkg::MAIN_BASE;
        end else if (CLK_EN_IN) begin
            if (state == fbcm_pkg::FBCM_WAIT && CFG_RD_VALID_IN) begin
                boot_loader <= ~CFG_RD_DATA_IN[fbcm_pkg::BOOT_HI];
                vec_base <= CFG_RD_DATA_IN[fbcm_pkg::BOOT_HI] ? fbcm_pkg::MAIN_BASE
                    : fbcm_pkg::LDR_BASE; // RULE20
            end else if (state == fbcm_pkg::FBCM_DONE) begin
                if (BOOT_SW_WE_IN && m.boot_mode[0]) begin
                    boot_loader <= BOOT_SW_IN; // RULE16
                end
                if (VEC_WE_IN && !m.boot_mode[0]) begin
                    vec_base <= VEC_PAGE_IN & ~fbcm_pkg::PAGE_MASK; // RULE17
                end
            end
        end
    end

    // applied fields follow the held word one cycle behind; boot selection and vector base follow their registers
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            CFG_VALID_OUT <= 1'b0;
            WDT_EN_OUT <= 1'b0;
            WDT_CLK_LIRC_OUT <= 1'b0;
            LIRC_ALWAYS_ON_OUT <= 1'b0;
            LIRC_PD_GATED_OUT <= 1'b0;
            SYSCLK_SRC_OUT <= fbcm_pkg::SYSCLK_IRC;
            SYSCLK_RSVD_OUT <= 1'b0;
            BOD_EN_OUT <= 1'b0;
            BOD_LEVEL_OUT <= '0;
            BOD_RST_EN_OUT <= 1'b0;
            GPIO_QUASI_OUT <= 1'b0;
            BOOT_MODE_OUT <= '0;
            BOOT_LOADER_OUT <= 1'b0;
            LOCKED_OUT <= 1'b1;
            VEC_BASE_OUT <= '0;
        end else if (CLK_EN_IN) begin
            CFG_VALID_OUT <= (state == fbcm_pkg::FBCM_DONE) && !REBOOT_IN;
            WDT_EN_OUT <= m.wdt_en; // RULE7
            WDT_CLK_LIRC_OUT <= m.wdt_lirc; // RULE7
            LIRC_ALWAYS_ON_OUT <= m.lirc_on; // RULE8
            LIRC_PD_GATED_OUT <= m.lirc_gated; // RULE8
            SYSCLK_SRC_OUT <= m.clk_src; // RULE9
            SYSCLK_RSVD_OUT <= m.clk_rsvd; // RULE9
            BOD_EN_OUT <= m.bod_en; // RULE10
            BOD_LEVEL_OUT <= m.bod_lvl; // RULE11
            BOD_RST_EN_OUT <= m.bod_rst; // RULE12
            GPIO_QUASI_OUT <= m.gpio_quasi; // RULE13
            BOOT_MODE_OUT <= m.boot_mode; // RULE14
            BOOT_LOADER_OUT <= boot_loader;
            LOCKED_OUT <= m.locked; // RULE18
            VEC_BASE_OUT <= vec_base;
        end
    end

    // cpu translation, one cycle; nothing maps before the word is applied
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            CPU_ACK_OUT <= 1'b0;
            CPU_HIT_OUT <= 1'b0;
            CPU_ORG_ADDR_OUT <= '0;
        end else if (CLK_EN_IN) begin
            CPU_ACK_OUT <= CPU_REQ_IN;
            CPU_HIT_OUT <= CPU_REQ_IN && CFG_VALID_OUT && hit; // RULE15
            CPU_ORG_ADDR_OUT <= org;
        end
    end

    // programming command check in the fixed flash-organization space
    always_comb begin
        next_ok = 1'b0;
        if (PROG_ERASE_IN && (PROG_ADDR_IN & fbcm_pkg::PAGE_MASK) != '0) begin
            next_ok = 1'b0; // RULE2
        end else if (PROG_ADDR_IN <= MAIN_LAST) begin
            next_ok = m.boot_mode != fbcm_pkg::FBCM_MAIN_ONLY; // RULE24
        end else if (PROG_ADDR_IN >= fbcm_pkg::LDR_BASE && PROG_ADDR_IN <= fbcm_pkg::LDR_LAST) begin
            next_ok = m.boot_mode != fbcm_pkg::FBCM_LDR_ONLY; // RULE3
        end else if (PROG_ADDR_IN >= fbcm_pkg::DATA_BASE && PROG_ADDR_IN <= fbcm_pkg::DATA_LAST) begin
            next_ok = 1'b1; // RULE1
        end else if (PROG_ADDR_IN == fbcm_pkg::CFG_ADDR) begin
            next_ok = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PROG_DONE_OUT <= 1'b0;
            PROG_OK_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            PROG_DONE_OUT <= PROG_REQ_IN;
            PROG_OK_OUT <= PROG_REQ_IN && CFG_VALID_OUT && next_ok; // RULE21
        end
    end

    // debug port filter; self-programming reads bypass this path entirely
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            DBG_VALID_OUT <= 1'b0;
            DBG_RDATA_OUT <= fbcm_pkg::LOCKED_DATA;
        end else if (CLK_EN_IN) begin
            DBG_VALID_OUT <= DBG_RD_VALID_IN;
            DBG_RDATA_OUT <= (m.locked && !DBG_IS_ID_IN) ? fbcm_pkg::LOCKED_DATA
                : DBG_RDATA_IN; // RULE18
        end
    end

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    a_cfg_read_addr: // RULE5
    assert property (CFG_RD_REQ_OUT |-> CFG_RD_ADDR_OUT == fbcm_pkg::CFG_ADDR)
        else $error("config read not at config address");
    a_word_held: // RULE6
    assert property (CFG_VALID_OUT && !REBOOT_IN |=> $stable(cfg_word))
        else $error("config word changed without reboot");
    a_mode_stable: // RULE25
    assert property ((CFG_VALID_OUT && CLK_EN_IN && !REBOOT_IN) [*2] |-> $stable(BOOT_MODE_OUT))
        else $error("boot mode changed between resets");
    a_wdt_decode: // RULE7
    assert property (CFG_VALID_OUT |-> WDT_EN_OUT == !cfg_word[fbcm_pkg::WDT_OFF_BIT])
        else $error("watchdog enable does not follow bit 31");
    a_data_window: // RULE1
    assert property (CLK_EN_IN && CPU_REQ_IN && CFG_VALID_OUT
        && CPU_ADDR_IN >= fbcm_pkg::DATA_BASE && CPU_ADDR_IN <= fbcm_pkg::DATA_LAST
        |=> CPU_HIT_OUT && CPU_ORG_ADDR_OUT == $past(CPU_ADDR_IN))
        else $error("data flash not at its fixed place");
    a_erase_aligned: // RULE2
    assert property (CLK_EN_IN && PROG_REQ_IN && PROG_ERASE_IN
        && PROG_ADDR_IN[8:0] != 9'h000 |=> !PROG_OK_OUT)
        else $error("unaligned erase accepted");
    a_main_protect: // RULE24
    assert property (CLK_EN_IN && PROG_REQ_IN && PROG_ADDR_IN <= MAIN_LAST
        && BOOT_MODE_OUT == 2'h3 && CFG_VALID_OUT |=> !PROG_OK_OUT)
        else $error("main region written in mode 11");
    a_vector_mirror: // RULE20
    assert property (CLK_EN_IN && CPU_REQ_IN && CFG_VALID_OUT && !BOOT_MODE_OUT[0]
        && CPU_ADDR_IN <= fbcm_pkg::PAGE_MASK
        |=> CPU_HIT_OUT && CPU_ORG_ADDR_OUT == ($past(vec_base) | $past(CPU_ADDR_IN)))
        else $error("vector page not mirrored");
    a_no_cross_read: // RULE19
    assert property (CLK_EN_IN && CPU_REQ_IN && BOOT_MODE_OUT == 2'h3 && !boot_loader
        && CPU_ADDR_IN >= fbcm_pkg::LDR_BASE && CPU_ADDR_IN <= fbcm_pkg::LDR_LAST
        |=> !CPU_HIT_OUT)
        else $error("loader readable while booting main alone");
    a_switch_ignored: // RULE16
    assert property (CFG_VALID_OUT && !BOOT_MODE_OUT[0] && !REBOOT_IN |=> $stable(boot_loader))
        else $error("boot switch acted with cross-execution");
    a_lock_filter: // RULE18
    assert property (CLK_EN_IN && DBG_RD_VALID_IN && m.locked && !DBG_IS_ID_IN
        |=> DBG_VALID_OUT && DBG_RDATA_OUT == fbcm_pkg::LOCKED_DATA)
        else $error("locked debug read leaked data");
endmodule : fbcm_top
`default_nettype wire

/* test/fbcm_flash_model.sv */
// fbcm_flash_model: flash array answering the configuration word read.
// assumes the requester holds its request until it has taken the valid pulse.
`timescale 1ns/1ns
`default_nettype none
module fbcm_flash_model (
    input wire logic clk_in,          // system clock
    input wire logic req_in,          // read request
    input wire logic [23:0] addr_in,  // read address
    input wire logic [31:0] word_in,  // word stored in the array
    output logic [31:0] data_out,     // read data
    output logic valid_out            // one-cycle data valid
);
    int cnt = 0;
    bit slow = 0;
    initial data_out = 32'h0;
    initial valid_out = 1'b0;
    // alternates a prompt and a slow answer; idle data toggles so no stale word is seen
    always @(posedge clk_in) begin
        valid_out <= 1'b0;
        data_out <= ~data_out;
        if (req_in && !valid_out && addr_in === fbcm_pkg::CFG_ADDR) begin
            cnt <= cnt + 1;
            if (cnt >= (slow ? 3 : 0)) begin
                valid_out <= 1'b1;
                data_out <= word_in;
                cnt <= 0;
                slow <= !slow;
            end
        end
    end
endmodule : fbcm_flash_model
`default_nettype wire

/* test/tb.sv */
// tb: self-checking bench for the boot configuration loader and map.
// assumes the flash model answers each configuration read.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 0, rst = 1, reboot = 0, rd_req, rd_valid, cpu_req = 0, ack, hit;
    logic bsw_we = 0, bsw = 0, vec_we = 0, p_req = 0, p_erase = 0, p_done, p_ok;
    logic d_valid = 0, d_id = 0, dv, cfg_valid, bl;
    logic [23:0] rd_addr, cpu_addr = 0, org, vec_page = 0, p_addr = 0, vbase;
    logic [31:0] rd_data, word = 32'h384f_ff3d, d_data = 0, dd;
    logic [31:0] f;
    int n_errors = 0, num_checks = 0;
    initial forever #4 clk = ~clk;
    fbcm_flash_model flash (.clk_in(clk), .req_in(rd_req), .addr_in(rd_addr), .word_in(word),
        .data_out(rd_data), .valid_out(rd_valid));
    fbcm_top #(.MAIN_KB(16)) dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(1'b1),
        .REBOOT_IN(reboot), .CFG_RD_REQ_OUT(rd_req), .CFG_RD_ADDR_OUT(rd_addr),
        .CFG_RD_DATA_IN(rd_data), .CFG_RD_VALID_IN(rd_valid), .CPU_REQ_IN(cpu_req),
        .CPU_ADDR_IN(cpu_addr), .CPU_ACK_OUT(ack), .CPU_HIT_OUT(hit), .CPU_ORG_ADDR_OUT(org),
        .BOOT_SW_WE_IN(bsw_we), .BOOT_SW_IN(bsw), .VEC_WE_IN(vec_we), .VEC_PAGE_IN(vec_page),
        .PROG_REQ_IN(p_req), .PROG_ERASE_IN(p_erase), .PROG_ADDR_IN(p_addr),
        .PROG_DONE_OUT(p_done), .PROG_OK_OUT(p_ok), .DBG_RD_VALID_IN(d_valid),
        .DBG_IS_ID_IN(d_id), .DBG_RDATA_IN(d_data), .DBG_VALID_OUT(dv), .DBG_RDATA_OUT(dd),
        .CFG_VALID_OUT(cfg_valid), .WDT_EN_OUT(f[0]), .WDT_CLK_LIRC_OUT(f[1]),
        .LIRC_ALWAYS_ON_OUT(f[2]), .LIRC_PD_GATED_OUT(f[3]), .SYSCLK_SRC_OUT(f[6:4]),
        .SYSCLK_RSVD_OUT(f[7]), .BOD_EN_OUT(f[8]), .BOD_LEVEL_OUT(f[10:9]),
        .BOD_RST_EN_OUT(f[11]), .GPIO_QUASI_OUT(f[12]), .BOOT_MODE_OUT(f[14:13]),
        .BOOT_LOADER_OUT(bl), .LOCKED_OUT(f[15]), .VEC_BASE_OUT(vbase));
    assign f[31:16] = 16'h0;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task give_verdict;
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task capture(input logic [31:0] w);
        @(negedge clk);
        word = w;
        reboot = 1;
        @(negedge clk);
        reboot = 0;
        for (int i = 0; i < 40 && cfg_valid !== 1'b1; i++) @(negedge clk);
        chk(cfg_valid, 1);
    endtask : capture
    task look(input logic [23:0] a, input logic h, input logic [23:0] o);
        @(negedge clk);
        cpu_req = 1;
        cpu_addr = a;
        @(negedge clk);
        cpu_req = 0;
        chk({ack, hit, org}, {1'b1, h, o});
    endtask : look
    task prog(input logic e, input logic [23:0] a, input logic ok);
        @(negedge clk);
        {p_req, p_erase, p_addr} = {1'b1, e, a};
        @(negedge clk);
        p_req = 0;
        chk({p_done, p_ok}, {1'b1, ok});
    endtask : prog
    task ctl(input logic bw, input logic b, input logic vw, input logic [23:0] v);
        @(negedge clk);
        {bsw_we, bsw, vec_we, vec_page} = {bw, b, vw, v};
        @(negedge clk);
        {bsw_we, vec_we} = 2'b00;
        @(negedge clk);
    endtask : ctl
    task dbg(input logic id, input logic [31:0] exp);
        @(negedge clk);
        {d_valid, d_id, d_data} = {1'b1, id, 32'h1234_5678};
        @(negedge clk);
        d_valid = 0;
        chk({dv, dd}, {1'b1, exp});
    endtask : dbg
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge clk);
        chk({cfg_valid, f[6:4], f[15]}, 5'h0f);
        rst = 0;
        for (int i = 0; i < 40 && cfg_valid !== 1'b1; i++) @(negedge clk);
        chk(rd_addr, 24'h30_0000);
        chk(f, 32'h0000_9d07);
        look(24'h00_0010, 1, 24'h10_0010);
        look(24'h00_0200, 1, 24'h00_0200);
        look(24'h01_f004, 1, 24'h01_f004);
        look(24'h10_0ffc, 1, 24'h10_0ffc);
        prog(1, 24'h00_0201, 0);
        prog(1, 24'h01_f200, 1);
        prog(0, 24'h10_0004, 1);
        ctl(1, 0, 1, 24'h00_0401);
        chk({bl, vbase}, {1'b1, 24'h00_0400});
        look(24'h00_0010, 1, 24'h00_0410);
        dbg(0, 32'hffff_ffff);
        dbg(1, 32'h1234_5678);
        word = 32'hffff_ff7f;
        repeat (10) @(negedge clk);
        chk({f[14:13], vbase}, {2'b00, 24'h00_0400});
        // opposite polarity on every field but watchdog bit 31, which stays low; reserved clock code included
        capture(32'h7abf_fbff);
        chk(f, 32'h0000_62ab);
        for (int m = 0; m < 4; m++) begin
            capture(32'hffff_ff3f | (m << 6));
            chk({f[15], f[14:13], bl}, {1'b0, m[1:0], !m[1]});
            look(24'h00_0010, 1, m[1] ? 24'h00_0010 : 24'h10_0010);
            look(24'h00_3ffc, m != 1, m != 1 ? 24'h00_3ffc : 24'h0);
            look(24'h00_4000, 0, 24'h0);
            look(24'h10_0010, !m[0], !m[0] ? 24'h10_0010 : 24'h0);
            prog(1, 24'h10_0000, m != 1);
            prog(1, 24'h00_0000, m != 3);
            dbg(0, 32'h1234_5678);
            ctl(1, !m[1] ? 1'b0 : 1'b1, 1, 24'h00_0600);
            chk({bl, vbase}, m[0] ? {!m[1] ? 1'b0 : 1'b1, m[1] ? 24'h0 : 24'h10_0000}
                : {!m[1], 24'h00_0600});
        end
        give_verdict();
    end
endmodule : tb
`default_nettype wire
